/* src/otp_osc_ctrl.sv */
`timescale 1ns/1ps
// Operation
// - a new tuning value makes the fast oscillator glide to it with no done flag.
// - the low-frequency source select picks which oscillator gives the 31 kHz clock.
// - the pll multiplies the fast oscillator by four, 32 MHz at most.
// - bit 6 of the tuning register enables the pll when set, disables when clear.
// - the pll runs only with source select 00 and config field 011 or 010.
// - the pll runs only with frequency select 111 or 110 (8 or 4 MHz).
// - enabling the pll keeps the core on its old clock for up to 2 ms of lock time.
// - after lock the core moves to the pll clock by itself.
// - the fast oscillator gives 8.0 MHz at the calibrated (zero) trim.
// - tuning touches only the fast oscillator, never the slow rc.
// - a lower tuning value slows the fast oscillator, a higher one speeds it up.
module otp_osc_ctrl #(
  parameter int LOCK_CYCLES = otp_pkg::OTP_LOCK_CYC
) (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        rst_n,
  // ahb-lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // oscillator and clock tree controls
  output logic      [5:0]  fast_osc_trim,
  output logic             low_freq_from_fast,
  output logic             pll_power,
  output logic             pll_locked,
  output logic             core_on_pll,
  output logic      [15:0] core_clk_khz
);

  // ========================================================
  // register state
  logic [5:0]  tune_target;
  logic        pll_enable_bit;
  logic        low_freq_source_select;
  logic [2:0]  freq_sel;
  logic [1:0]  clock_source_select;
  logic [2:0]  config_osc_field;
  logic [5:0]  trim_level;
  logic [6:0]  glide_cnt;
  logic [17:0] lock_cnt;
  otp_pkg::otp_pll_state_t pll_state;
  otp_pkg::otp_pll_state_t next_pll_state;

  // ========================================================
  // bus data-phase capture
  logic        dp_write;
  logic [3:0]  dp_addr;
  logic        dp_hit;

  // address phase decode; the low nibble selects a register, haddr[31:4] and haddr[1:0] must be zero
  wire         addr_accept = hsel & htrans[1] & hready;
  wire         addr_hit    = (haddr[31:4] == 28'h0000000) && (haddr[1:0] == 2'b00);
  wire         wr_tune     = dp_write & dp_hit & (dp_addr == otp_pkg::OTP_TUNE_OFS);
  wire         wr_ctrl     = dp_write & dp_hit & (dp_addr == otp_pkg::OTP_CTRL_OFS);
  wire         wr_cfg      = dp_write & dp_hit & (dp_addr == otp_pkg::OTP_CFG_OFS);

  // zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

  // read view of each register, unmapped offsets read zero
  wire [31:0] rd_tune = {24'h000000, low_freq_source_select, pll_enable_bit, 1'b0, 5'h00}
                        | {26'h0000000, tune_target};
  wire [31:0] rd_ctrl = {25'h0000000, freq_sel, 2'b00, clock_source_select};
  wire [31:0] rd_cfg  = {29'h00000000, config_osc_field};
  wire [31:0] rd_stat = {21'h000000, core_on_pll, pll_locked, pll_power, 2'b00, trim_level};
  wire [31:0] rd_mux  = !addr_hit                              ? 32'h00000000 :
                        (haddr[3:0] == otp_pkg::OTP_TUNE_OFS) ? rd_tune :
                        (haddr[3:0] == otp_pkg::OTP_CTRL_OFS) ? rd_ctrl :
                        (haddr[3:0] == otp_pkg::OTP_CFG_OFS)  ? rd_cfg  : rd_stat;

  // latch the address phase for the following data phase
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      dp_write <= 1'b0;
      dp_addr  <= 4'h0;
      dp_hit   <= 1'b0;
    end else begin
      dp_write <= addr_accept & hwrite;
      dp_addr  <= haddr[3:0];
      dp_hit   <= addr_hit;
    end
  end

  // read data is sampled at the address phase so it stands from a flop
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      hrdata <= 32'h00000000;
    end else if (addr_accept & ~hwrite) begin
      hrdata <= rd_mux;
    end
  end

  // ========================================================
  // software registers
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      tune_target            <= otp_pkg::OTP_TUNE_RST[otp_pkg::OTP_TUNE_MSB:0];
      pll_enable_bit         <= otp_pkg::OTP_TUNE_RST[otp_pkg::OTP_PLL_ENABLE_BIT_BIT];
      low_freq_source_select <= otp_pkg::OTP_TUNE_RST[otp_pkg::OTP_LFSRC_BIT];
    end else if (wr_tune) begin
      tune_target            <= hwdata[otp_pkg::OTP_TUNE_MSB:0];
      pll_enable_bit         <= hwdata[otp_pkg::OTP_PLL_ENABLE_BIT_BIT];
      low_freq_source_select <= hwdata[otp_pkg::OTP_LFSRC_BIT];
    end
  end

  // clock selection fields; the config field is writable here as well
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      freq_sel            <= otp_pkg::OTP_FREQ_RST;
      clock_source_select <= otp_pkg::OTP_SCS_RST;
      config_osc_field    <= otp_pkg::OTP_CFG_RST;
    end else begin
      if (wr_ctrl) begin
        freq_sel            <= hwdata[otp_pkg::OTP_FREQ_LSB +: 3];
        clock_source_select <= hwdata[1:0];
      end
      if (wr_cfg) begin
        config_osc_field <= hwdata[2:0];
      end
    end
  end

  // ========================================================
  // trim glide: one step per glide period, no completion flag
  wire glide_tick = (glide_cnt == 7'(otp_pkg::OTP_GLIDE_CYC - 1));
  wire trim_below = $signed(trim_level) < $signed(tune_target);
  wire trim_above = $signed(trim_level) > $signed(tune_target);

  // the step cadence runs freely so a retarget never restarts it
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      glide_cnt <= 7'h00;
    end else begin
      glide_cnt <= glide_tick ? 7'h00 : glide_cnt + 7'h01;
    end
  end

  // higher trim is a faster oscillator, lower is slower
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      trim_level <= otp_pkg::OTP_TUNE_RST[otp_pkg::OTP_TUNE_MSB:0];
    end else if (glide_tick & trim_below) begin
      trim_level <= trim_level + 6'h01;
    end else if (glide_tick & trim_above) begin
      trim_level <= trim_level - 6'h01;
    end
  end

  // only the fast oscillator takes the trim; the slow rc has no trim path
  assign fast_osc_trim = trim_level;

  // ========================================================
  // pll qualification and lock sequencing
  wire mode_ok  = (clock_source_select == otp_pkg::OTP_SCS_PRIMARY) &&
                  ((config_osc_field == otp_pkg::OTP_CFG_PLL_A) ||
                   (config_osc_field == otp_pkg::OTP_CFG_PLL_B));
  wire freq_ok  = (freq_sel == otp_pkg::OTP_FREQ_8M) ||
                  (freq_sel == otp_pkg::OTP_FREQ_4M);
  wire pll_run  = pll_enable_bit & mode_ok & freq_ok;
  wire lock_end = (lock_cnt == 18'(LOCK_CYCLES - 1));

  // losing any qualifier drops straight back to the plain clock
  always_comb begin
    next_pll_state = pll_state;
    case (pll_state)
      otp_pkg::OTP_PLL_OFF: begin
        if (pll_run) begin
          next_pll_state = otp_pkg::OTP_PLL_LOCK;
        end
      end
      otp_pkg::OTP_PLL_LOCK: begin
        if (!pll_run) begin
          next_pll_state = otp_pkg::OTP_PLL_OFF;
        end else if (lock_end) begin
          next_pll_state = otp_pkg::OTP_PLL_ON;
        end
      end
      otp_pkg::OTP_PLL_ON: begin
        if (!pll_run) begin
          next_pll_state = otp_pkg::OTP_PLL_OFF;
        end
      end
      default: begin
        next_pll_state = otp_pkg::OTP_PLL_OFF;
      end
    endcase
  end

  // state register and lock timer; core stays on its old clock meanwhile
  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      pll_state <= otp_pkg::OTP_PLL_OFF;
      lock_cnt  <= 18'h00000;
    end else begin
      pll_state <= next_pll_state;
      lock_cnt  <= (pll_state == otp_pkg::OTP_PLL_LOCK) ? lock_cnt + 18'h00001 : 18'h00000;
    end
  end

  assign pll_power   = (pll_state != otp_pkg::OTP_PLL_OFF);
  assign pll_locked  = (pll_state == otp_pkg::OTP_PLL_ON);
  assign core_on_pll = (pll_state == otp_pkg::OTP_PLL_ON);

  // ========================================================
  // core frequency report
  function automatic logic [15:0] OTP_FREQ_SEL_KHZ(input logic [2:0] sel);
    OTP_FREQ_SEL_KHZ = otp_pkg::OTP_FREQ_KHZ[sel];
  endfunction

  wire [15:0] base_khz = OTP_FREQ_SEL_KHZ(freq_sel);
  wire [15:0] pll_khz  = base_khz << otp_pkg::OTP_PLL_SHIFT;

  // low band source pick; fast-derived when the select bit is set
  assign low_freq_from_fast = (freq_sel == otp_pkg::OTP_FREQ_LF) &
                              low_freq_source_select;

  always_ff @(posedge sys_clk) begin
    if (!rst_n) begin
      core_clk_khz <= otp_pkg::OTP_FREQ_KHZ[otp_pkg::OTP_FREQ_RST];
    end else begin
      core_clk_khz <= (pll_state == otp_pkg::OTP_PLL_ON) ? pll_khz : base_khz;
    end
  end

  // ========================================================
  // checks
  localparam int GLIDE_WAIT = 126;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_lock_start;
    $rose(pll_run) && (pll_state == otp_pkg::OTP_PLL_OFF);
  endsequence

  sequence s_hold_old;
    !core_on_pll [*8];
  endsequence

  a_pll_mode_gate: assert property (
    pll_power |-> ($past(clock_source_select) == 2'h0) &&
                  ($past(config_osc_field) inside {3'h3, 3'h2}))
    else $error("pll powered outside an internal pll mode");

  a_pll_freq_gate: assert property (
    core_on_pll |-> $past(freq_sel[2:1]) == 2'b11)
    else $error("core on pll with bad frequency select");

  a_lock_delay: assert property (
    s_lock_start |=> s_hold_old)
    else $error("core switched before lock time");

  a_lock_switch: assert property (
    (pll_state == otp_pkg::OTP_PLL_LOCK) && lock_end && pll_run
      |=> core_on_pll ##1 core_clk_khz == $past(pll_khz))
    else $error("core did not switch after lock");

  a_pll_times_four: assert property (
    core_on_pll |=> (core_clk_khz == ($past(base_khz) << 2)) &&
                    (core_clk_khz <= 16'h7D00))
    else $error("pll clock is not four times base");

  a_trim_glides: assert property (
    (trim_level != tune_target) |-> ##[1:GLIDE_WAIT] $changed(trim_level))
    else $error("trim did not move toward target");

  a_trim_direction: assert property (
    $changed(trim_level) |-> (trim_level == $past(trim_level) + 6'h01) ==
                             ($signed($past(tune_target)) > $signed($past(trim_level))))
    else $error("trim stepped the wrong way");

  a_reset_plain: assert property (
    $rose(rst_n) |-> !pll_enable_bit && !core_on_pll)
    else $error("pll active right after reset");

  a_lf_source: assert property (
    (freq_sel == 3'h0) |-> low_freq_from_fast == low_freq_source_select)
    else $error("low band source select ignored");

  a_nominal_8m: assert property (
    (freq_sel == 3'h7) && !core_on_pll |=> core_clk_khz == 16'h1F40)
    else $error("fast oscillator not 8 MHz nominal");

  a_pll_enable: assert property (
    wr_tune && !hwdata[6] |=> !pll_enable_bit ##1 !pll_power)
    else $error("pll enable bit ignored");

endmodule

/* src/otp_pkg.sv */
// ==========================================================
// shared constants for the oscillator tune / pll control
package otp_pkg;

  // ========================================================
  // register byte offsets
  localparam logic [3:0] OTP_TUNE_OFS   = 4'h0;  // osc_tuning_reg
  localparam logic [3:0] OTP_CTRL_OFS   = 4'h4;  // osc_control_reg
  localparam logic [3:0] OTP_CFG_OFS    = 4'h8;  // config_osc_field holder
  localparam logic [3:0] OTP_STAT_OFS   = 4'hC;  // live status, read only

  // ========================================================
  // field positions
  localparam int OTP_TUNE_MSB      = 5;   // signed trim value [5:0]
  localparam int OTP_PLL_ENABLE_BIT_BIT     = 6;   // pll_enable_bit
  localparam int OTP_LFSRC_BIT     = 7;   // low_freq_source_select
  localparam int OTP_FREQ_LSB      = 4;   // frequency select [6:4]
  localparam int OTP_STAT_PWR_BIT  = 8;
  localparam int OTP_STAT_LOCK_BIT = 9;
  localparam int OTP_STAT_CORE_BIT = 10;

  // ========================================================
  // reset values
  localparam logic [7:0] OTP_TUNE_RST = 8'h00;
  localparam logic [2:0] OTP_FREQ_RST = 3'h6;
  localparam logic [1:0] OTP_SCS_RST  = 2'h0;
  localparam logic [2:0] OTP_CFG_RST  = 3'h3;

  // ========================================================
  // pll qualifying codes
  localparam logic [1:0] OTP_SCS_PRIMARY = 2'h0;
  localparam logic [2:0] OTP_CFG_PLL_A   = 3'h3;
  localparam logic [2:0] OTP_CFG_PLL_B   = 3'h2;
  localparam logic [2:0] OTP_FREQ_8M     = 3'h7;
  localparam logic [2:0] OTP_FREQ_4M     = 3'h6;
  localparam logic [2:0] OTP_FREQ_LF     = 3'h0;
  localparam int         OTP_PLL_SHIFT   = 2;   // multiply by four

  // ========================================================
  // base clock in kHz per frequency select code
  localparam logic [15:0] OTP_FREQ_KHZ [0:7] = '{
    16'h001F, 16'h007D, 16'h00FA, 16'h01F4,
    16'h03E8, 16'h07D0, 16'h0FA0, 16'h1F40};
  localparam logic [15:0] OTP_PLL_MAX_KHZ = 16'h7D00;

  // ========================================================
  // timing
  localparam int OTP_CLK_PERIOD_NS = 8;
  localparam int OTP_LOCK_NS       = 2000000;
  localparam int OTP_LOCK_CYC      = OTP_LOCK_NS / OTP_CLK_PERIOD_NS;
  localparam int OTP_GLIDE_NS      = 1000;
  localparam int OTP_GLIDE_CYC     = OTP_GLIDE_NS / OTP_CLK_PERIOD_NS;

  // ========================================================
  // pll sequencer states, one-hot
  typedef enum logic [2:0] {
    OTP_PLL_OFF  = 3'b001,
    OTP_PLL_LOCK = 3'b010,
    OTP_PLL_ON   = 3'b100
  } otp_pll_state_t;

endpackage

/* verif/testbench.sv */
`timescale 1ns/1ps
module testbench;
  // ==========================================================
  // settings: short lock time keeps the run brief
  localparam int LOCK  = 20;
  localparam int LIMIT = 60000;
  // {pll expected, source select, config field, frequency select}
  localparam logic [8:0] MODES [0:7] = '{9'h11F, 9'h116, 9'h00F, 9'h05F,
                                         9'h01D, 9'h096, 9'h018, 9'h0E7};

  // clock, reset and bus
  logic        sys_clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  // oscillator side
  logic [5:0]  fast_osc_trim;
  logic        low_freq_from_fast;
  logic        pll_power;
  logic        pll_locked;
  logic        core_on_pll;
  logic [15:0] core_clk_khz;
  // bench state
  logic        rd_done;
  logic [31:0] exp_q [$];
  logic [31:0] rnd;
  logic [8:0]  m;
  logic [5:0]  tgt;
  logic [5:0]  cur;
  int          n;
  int          num_errors = 0;
  int          num_checks = 0;
  int          cycles     = 0;

  otp_osc_ctrl #(.LOCK_CYCLES(LOCK)) u_dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .fast_osc_trim(fast_osc_trim), .low_freq_from_fast(low_freq_from_fast),
    .pll_power(pll_power), .pll_locked(pll_locked), .core_on_pll(core_on_pll),
    .core_clk_khz(core_clk_khz));

  // ==========================================================
  // clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    logic [31:0] y;
    y = x ^ (x << 13);
    y = y ^ (y >> 17);
    y = y ^ (y << 5);
    return y;
  endfunction

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // one single transfer; hready is sampled high before anything moves on
  task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= wr;
    hsize  <= 3'h2;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge sys_clk);
    while (hreadyout !== 1'b1) @(posedge sys_clk);
  endtask

  task automatic rd(input logic [31:0] a, input logic [31:0] e);
    exp_q.push_back(e);
    bus(1'b0, a, 32'h0);
    rd_done <= 1'b1;
    @(posedge sys_clk);
    rd_done <= 1'b0;
  endtask

  // read monitor: oldest note against the data that stood at the sampling edge
  always @(posedge sys_clk) begin
    if (rd_done === 1'b1 && exp_q.size() > 0) begin
      chk(hrdata, exp_q.pop_front());
    end
  end

  // hang guard, sized well above the glide and lock waits
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      num_errors++;
      tally_and_finish();
    end
  end

  // ==========================================================
  // main sequence
  initial begin
    rst_n = 1'b0; hsel = 1'b0; haddr = 32'h0; htrans = 2'h0; hwrite = 1'b0;
    hsize = 3'h2; hwdata = 32'h0; rd_done = 1'b0; rnd = 32'd30;
    repeat (4) @(posedge sys_clk);
    chk(32'(pll_power), 32'h0);
    chk(32'(core_on_pll), 32'h0);
    chk(32'(fast_osc_trim), 32'h0);
    chk(32'(core_clk_khz), 32'h0FA0);
    chk(32'(hresp), 32'h0);
    chk(32'(hreadyout), 32'h1);
    rst_n <= 1'b1;
    rd(32'h0, 32'h0);
    rd(32'h4, 32'h60);
    rd(32'h8, 32'h3);
    bus(1'b1, 32'h10, 32'hFFFF_FFFF);
    rd(32'h10, 32'h0);
    rd(32'h0, 32'h0);
    $display("test reset and map done");
    // two qualifying and six disqualifying modes
    for (int i = 0; i < 8; i++) begin
      m = MODES[i];
      bus(1'b1, 32'h0, 32'h0);
      bus(1'b1, 32'h4, {25'h0, m[2:0], 2'h0, m[7:6]});
      bus(1'b1, 32'h8, {29'h0, m[5:3]});
      bus(1'b1, 32'h0, 32'h40);
      repeat (2) @(posedge sys_clk);
      chk(32'(pll_power), 32'(m[8]));
      chk(32'(core_on_pll), 32'h0);
      if (m[8]) begin
        n = 0;
        while (core_on_pll !== 1'b1 && n < LOCK + 20) begin
          @(posedge sys_clk);
          n++;
        end
        chk(32'(n), 32'(LOCK));
        chk(32'(pll_locked), 32'h1);
        @(posedge sys_clk);
        chk(32'(core_clk_khz), m[0] ? 32'h7D00 : 32'h3E80);
        rd(32'hC, 32'h700);
      end else begin
        repeat (LOCK + 3) @(posedge sys_clk);
        chk(32'(core_on_pll), 32'h0);
        chk(32'(core_clk_khz), 32'(otp_pkg::OTP_FREQ_KHZ[m[2:0]]));
      end
      rd(32'h0, 32'h40);
      bus(1'b1, 32'h0, 32'h0);
      repeat (2) @(posedge sys_clk);
      chk(32'(pll_power), 32'h0);
    end
    $display("test pll modes done");
    // low-frequency source select, then glide with the slow clock in use
    bus(1'b1, 32'h4, 32'h0);
    bus(1'b1, 32'h0, 32'h80);
    @(posedge sys_clk);
    chk(32'(low_freq_from_fast), 32'h1);
    bus(1'b1, 32'h0, 32'h0);
    @(posedge sys_clk);
    chk(32'(low_freq_from_fast), 32'h0);
    for (int k = 0; k < 3; k++) begin
      rnd = xs(rnd);
      tgt = rnd[5:0];
      cur = fast_osc_trim;
      bus(1'b1, 32'h0, {24'h0, 2'b10, tgt});
      repeat (131) @(posedge sys_clk);
      if (tgt != cur) begin
        chk(32'(fast_osc_trim != cur && (($signed(fast_osc_trim) > $signed(cur)) ==
            ($signed(tgt) > $signed(cur)))), 32'h1);
      end
      n = 0;
      while (fast_osc_trim !== tgt && n < 9000) begin
        @(posedge sys_clk);
        n++;
      end
      chk(32'(fast_osc_trim), 32'(tgt));
      rd(32'hC, {26'h0, tgt});
      chk(32'(low_freq_from_fast), 32'h1);
      chk(32'(core_clk_khz), 32'h001F);
    end
    $display("test glide done");
    repeat (4) @(posedge sys_clk);
    tally_and_finish();
  end
endmodule
